/* File: hw/sli_led.sv */
`timescale 1ns/1ps
// Operation
// R1: while enumerating, green blinks at 10 Hz.
// R2: while operating, green is off for each running command.
// R3: enumerated and idle, green stays continuously lit.
// R4: idle 7 s or more, green goes off 10 ms each second.
// R5: single-colour variant blinks green at 1 Hz on fatal error.
// R6: two-element variant drives separate green and red elements.
// R7: two-element variant blinks red at 1 Hz on fatal error.
// R8: two-element variant shows orange while target reset is active.
// R9: fatal error wins over all; a command start restarts idle timer.
module sli_led
    import sli_pkg::*;
#(
    parameter bit BICOLOR = 1'b1,                   // two-element indicator fitted
    parameter int unsigned MS_DIV = MS_CYC,          // cycles per millisecond
    parameter int unsigned ENUM_HALF_MS = ENUM_HALF_MSN,   // 10 Hz half period
    parameter int unsigned FATAL_HALF_MS = FATAL_HALF_MSN, // 1 Hz half period
    parameter int unsigned IDLE_MS = IDLE_HB_MSN,
    parameter int unsigned HB_MS = HB_PERIOD_MSN,
    parameter int unsigned HB_OFF = HB_OFF_MSN
)(
    input wire logic i_clk,             // 100 MHz system clock
    input wire logic i_rst_b,           // sync reset, active low
    input wire logic i_enumerating,     // host link enumeration in progress
    input wire logic i_busy,            // a command is being carried out
    input wire logic i_fatal,           // fatal error condition
    input wire logic i_tgt_reset,       // reset asserted on target
    output logic o_led_green,           // green element, high = lit
    output logic o_led_red              // red element, high = lit (bicolor only)
);
    typedef enum logic [4:0] {
        SLI_ENUM  = 5'h01,
        SLI_BUSY  = 5'h02,
        SLI_IDLE  = 5'h04,
        SLI_RST   = 5'h08,
        SLI_FATAL = 5'h10
    } sli_mode_t;

    sli_status_t st;
    sli_led_t led_d;
    sli_mode_t mode;
    logic busy_q, cmd_start, ms_tick;
    logic [15:0] idle_ms_q;
    logic [15:0] hb_ms_q;
    logic [15:0] blink_ms_q;
    logic blink_q, hb_on_q;

    // state inputs come from same-clock control logic, so no synchroniser
    assign st = '{enumerating: i_enumerating, busy: i_busy, fatal: i_fatal, tgt_reset: i_tgt_reset};
    assign cmd_start = st.busy && !busy_q;

    sli_tick #(.DIV(MS_DIV)) u_ms (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clr(1'b0),
        .o_tick(ms_tick)
    );

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            busy_q <= 1'b0;
        else
            busy_q <= st.busy;
    end

    always_comb
    begin
        if (st.fatal)
            mode = SLI_FATAL; // see R9
        else if (BICOLOR && st.tgt_reset)
            mode = SLI_RST;
        else if (st.enumerating)
            mode = SLI_ENUM;
        else if (st.busy)
            mode = SLI_BUSY;
        else
            mode = SLI_IDLE;
    end

    // idle timer saturates; a command start or any mode other than idle restarts it
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || cmd_start || mode != SLI_IDLE)
            idle_ms_q <= 16'h0; // see R9
        else if (ms_tick && idle_ms_q < 16'(IDLE_MS))
            idle_ms_q <= idle_ms_q + 16'h1;
    end

    // heartbeat phase free-runs once the idle time is reached
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || idle_ms_q < 16'(IDLE_MS))
            hb_ms_q <= 16'h0;
        else if (ms_tick)
            hb_ms_q <= (hb_ms_q == 16'(HB_MS - 1)) ? 16'h0 : hb_ms_q + 16'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            hb_on_q <= 1'b0;
        else
            hb_on_q <= (idle_ms_q >= 16'(IDLE_MS)) && (hb_ms_q < 16'(HB_OFF)); // see R4
    end

    // shared blink generator; restarts when the mode changes
    sli_mode_t mode_q;
    logic blink_now;

    // blink_q is stale in the entry cycle; force the on phase there
    assign blink_now = (mode != mode_q) ? 1'b1 : blink_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            mode_q <= SLI_IDLE;
        else
            mode_q <= mode;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || mode != mode_q)
        begin
            blink_ms_q <= 16'h0;
            blink_q <= 1'b1;
        end
        else if (ms_tick)
        begin
            if (blink_ms_q == 16'((mode == SLI_FATAL ? FATAL_HALF_MS : ENUM_HALF_MS) - 1))
            begin
                blink_ms_q <= 16'h0;
                blink_q <= !blink_q; // see R1, R5, R7
            end
            else
                blink_ms_q <= blink_ms_q + 16'h1;
        end
    end

    always_comb
    begin
        led_d = '{green: 1'b0, red: 1'b0};
        case (mode)
            SLI_FATAL:
            begin
                if (BICOLOR)
                    led_d.red = blink_now; // see R7
                else
                    led_d.green = blink_now; // see R5
            end
            SLI_RST:
                led_d = '{green: 1'b1, red: 1'b1}; // see R8
            SLI_ENUM:
                led_d.green = blink_now; // see R1
            SLI_BUSY:
                led_d.green = 1'b0; // see R2
            SLI_IDLE:
                led_d.green = !hb_on_q; // see R3, R4
            default:
                led_d.green = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_led_green <= 1'b0;
            o_led_red <= 1'b0;
        end
        else
        begin
            o_led_green <= led_d.green; // see R6
            o_led_red <= BICOLOR ? led_d.red : 1'b0;
        end
    end

    property p_busy_off; // see R2
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_busy && !i_fatal && !i_enumerating && !(BICOLOR && i_tgt_reset)) |=> !o_led_green;
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("green lit during command"); // see R2

    property p_fatal_prio; // see R9
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(i_fatal) ##1 i_fatal |=> (BICOLOR ? o_led_red && !o_led_green : o_led_green);
    endproperty
    a_fatal_prio: assert property (p_fatal_prio) else $error("fatal pattern missing"); // see R9

    property p_orange; // see R8
        @(posedge i_clk) disable iff (!i_rst_b)
        (BICOLOR && i_tgt_reset && !i_fatal) |=> (o_led_green && o_led_red);
    endproperty
    a_orange: assert property (p_orange) else $error("no orange on target reset"); // see R8

    property p_idle_lit; // see R3
        @(posedge i_clk) disable iff (!i_rst_b)
        (mode == SLI_IDLE && idle_ms_q < 16'(IDLE_MS)) ##1 (mode == SLI_IDLE) |=> o_led_green;
    endproperty
    a_idle_lit: assert property (p_idle_lit) else $error("idle green not lit"); // see R3

    property p_restart; // see R9
        @(posedge i_clk) disable iff (!i_rst_b)
        cmd_start |=> (idle_ms_q == 16'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("idle timer not restarted"); // see R9

    property p_red_only_bicolor; // see R6
        @(posedge i_clk) disable iff (!i_rst_b)
        !BICOLOR |-> !o_led_red;
    endproperty
    a_red_only_bicolor: assert property (p_red_only_bicolor) else $error("red lit on single colour"); // see R6

    property p_hb; // see R4
        @(posedge i_clk) disable iff (!i_rst_b)
        (mode == SLI_IDLE && mode_q == SLI_IDLE && hb_on_q) |=> !o_led_green;
    endproperty
    a_hb: assert property (p_hb) else $error("heartbeat not dark"); // see R4

    property p_enum_blink; // see R1
        @(posedge i_clk) disable iff (!i_rst_b)
        (mode == SLI_ENUM && mode_q == SLI_ENUM) |=> (o_led_green == $past(blink_q));
    endproperty
    a_enum_blink: assert property (p_enum_blink) else $error("enum blink wrong"); // see R1

    c_enum: cover property (@(posedge i_clk) disable iff (!i_rst_b) mode == SLI_ENUM && $fell(blink_q));
    c_busy: cover property (@(posedge i_clk) disable iff (!i_rst_b) cmd_start);
    c_hb: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(hb_on_q));
    c_fatal: cover property (@(posedge i_clk) disable iff (!i_rst_b) mode == SLI_FATAL && $rose(blink_q));
endmodule

/* File: hw/sli_pkg.sv */
package sli_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned ENUM_BLINK_HZ = 10;
    localparam int unsigned FATAL_BLINK_HZ = 1;
    localparam int unsigned HB_OFF_MS = 10;
    localparam int unsigned HB_PERIOD_MS = 1000;
    localparam int unsigned IDLE_HB_S = 7;
    // half periods, in cycles
    localparam int unsigned ENUM_HALF_CYC = CLK_HZ / (2 * ENUM_BLINK_HZ);
    localparam int unsigned FATAL_HALF_CYC = CLK_HZ / (2 * FATAL_BLINK_HZ);
    // half periods, in milliseconds
    localparam int unsigned ENUM_HALF_MSN = 1000 / (2 * ENUM_BLINK_HZ);
    localparam int unsigned FATAL_HALF_MSN = 1000 / (2 * FATAL_BLINK_HZ);
    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam int unsigned HB_OFF_MSN = HB_OFF_MS;
    localparam int unsigned HB_PERIOD_MSN = HB_PERIOD_MS;
    localparam int unsigned IDLE_HB_MSN = IDLE_HB_S * 1000;

    typedef struct packed {
        logic enumerating;
        logic busy;
        logic fatal;
        logic tgt_reset;
    } sli_status_t;

    typedef struct packed {
        logic green;
        logic red;
    } sli_led_t;
endpackage

/* File: hw/sli_tick.sv */
`timescale 1ns/1ps
module sli_tick
    import sli_pkg::*;
#(
    parameter int unsigned DIV = 100_000
)(
    input wire logic i_clk,   // system clock
    input wire logic i_rst_b, // sync reset, active low
    input wire logic i_clr,   // restart the count
    output logic o_tick       // one-cycle pulse every DIV cycles
);
    logic [31:0] cnt_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || i_clr)
        begin
            cnt_q <= 32'h0;
            o_tick <= 1'b0;
        end
        else if (cnt_q == DIV - 1)
        begin
            cnt_q <= 32'h0;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            o_tick <= 1'b0;
        end
    end
endmodule

/* File: verification/sli_led_model.sv */
`timescale 1ns/1ps
module sli_led_model (
    input wire logic i_green,    // green element, high = lit
    input wire logic i_red,      // red element, high = lit
    output logic [1:0] o_colour  // 0 off, 1 green, 2 red, 3 orange
);
    // both elements lit mix to orange
    assign o_colour = {i_red, i_green};
endmodule

/* File: verification/sli_led_tb.sv */
`timescale 1ns/1ps
module sli_led_tb;
    import sli_pkg::*;
    localparam int MSD = 4;
    localparam int ENH = 2;
    localparam int FAH = 5;
    localparam int IDL = 20;
    localparam int HBP = 10;
    localparam int HBO = 2;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    sli_status_t st = '0;
    logic [1:0] led2;
    logic [1:0] led1;
    logic [1:0] colour;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    sli_status_t row_in[8] = '{4'h0, 4'h4, 4'h0, 4'h8, 4'h1, 4'h9, 4'h7, 4'h0};
    logic [1:0] row_bi[8] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h1};
    logic [1:0] row_mo[8] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};

    initial
    begin
        forever #5 i_clk = ~i_clk;
    end

    sli_led #(.BICOLOR(1'b1), .MS_DIV(MSD), .ENUM_HALF_MS(ENH), .FATAL_HALF_MS(FAH), .IDLE_MS(IDL),
        .HB_MS(HBP), .HB_OFF(HBO)) i_sli_led (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_enumerating(st.enumerating), .i_busy(st.busy), .i_fatal(st.fatal), .i_tgt_reset(st.tgt_reset),
        .o_led_green(led2[0]), .o_led_red(led2[1]));
    // single-colour variant sees the same stimulus
    sli_led #(.BICOLOR(1'b0), .MS_DIV(MSD), .ENUM_HALF_MS(ENH), .FATAL_HALF_MS(FAH), .IDLE_MS(IDL),
        .HB_MS(HBP), .HB_OFF(HBO)) i_sli_led_mono (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_enumerating(st.enumerating), .i_busy(st.busy), .i_fatal(st.fatal), .i_tgt_reset(st.tgt_reset),
        .o_led_green(led1[0]), .o_led_red(led1[1]));
    sli_led_model i_sli_led_model (.i_green(led2[0]), .i_red(led2[1]), .o_colour(colour));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tk(input int k);
        repeat (k)
        begin
            @(posedge i_clk);
            #1;
        end
    endtask

    task automatic drv(input sli_status_t s);
        @(posedge i_clk);
        st <= s;
        #1;
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? led2[0] : (sel == 1) ? led2[1] : led1[0];
    endfunction

    // skips the stretch in progress so only a whole one is measured
    task automatic run_len(input int sel, input logic lvl, output int len);
        int g;
        g = 0;
        len = 0;
        while (pick(sel) === lvl && g < 400)
        begin
            tk(1);
            g++;
        end
        while (pick(sel) !== lvl && g < 400)
        begin
            tk(1);
            g++;
        end
        while (pick(sel) === lvl && g < 400)
        begin
            tk(1);
            g++;
            len++;
        end
    endtask

    initial
    begin
        tk(1);
        check({14'h0, led2, led1}, 16'h0000);
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        tk(3);
        $display("reset test done");
        for (int r = 0; r < 8; r++)
        begin
            drv(row_in[r]);
            tk(3);
            check({14'h0, colour}, {14'h0, row_bi[r]});
            check({14'h0, led1}, {14'h0, row_mo[r]});
        end
        $display("table test done");
        drv(4'h8);
        run_len(0, 1'b1, n);
        check(16'(n), 16'(ENH * MSD));
        run_len(0, 1'b0, n);
        check(16'(n), 16'(ENH * MSD));
        $display("enumerate blink test done");
        drv(4'h3);
        // red starts in the forced on phase here, so measure off first to skip the shortened entry phase
        run_len(1, 1'b0, n);
        check(16'(n), 16'(FAH * MSD));
        run_len(1, 1'b1, n);
        check(16'(n), 16'(FAH * MSD));
        check({15'h0, led2[0]}, 16'h0000);
        run_len(2, 1'b1, n);
        check(16'(n), 16'(FAH * MSD));
        $display("fatal blink test done");
        drv(4'h0);
        tk(60);
        check({15'h0, led2[0]}, 16'h0001);
        drv(4'h4);
        drv(4'h0);
        // one-cycle command darkens green for exactly one cycle, starting one cycle after the command
        check({15'h0, led2[0]}, 16'h0000);
        tk(1);
        n = 0;
        while (led2[0] !== 1'b0 && n < 300)
        begin
            tk(1);
            n++;
        end
        // timer restarted by the command, so no early heartbeat
        check({15'h0, n >= IDL * MSD - 4 && n <= (IDL + HBP) * MSD + 8}, 16'h0001);
        run_len(0, 1'b0, n);
        check(16'(n), 16'(HBO * MSD));
        run_len(0, 1'b1, n);
        check(16'(n), 16'((HBP - HBO) * MSD));
        $display("heartbeat test done");
        give_verdict();
    end
endmodule
